/* File: pof_defs.svh */
/*
 * Register offsets, control field positions, reset values and stream codes
 * for the pixel output formatter. Assumes inclusion by its bare name.
 */
`ifndef POF_DEFS_SVH
`define POF_DEFS_SVH

`define POF_ADDR_FRAME 9'h19a
`define POF_ADDR_CTRL 9'h19b
`define POF_CTRL_RESET 16'h0200
`define POF_CTRL_MASK 16'h4ff8
`define POF_BIT_BAYER 14
`define POF_BIT_SYNC 11
`define POF_BIT_BYPASS 10
`define POF_BIT_INV 9
`define POF_BIT_RGB 8
`define POF_FMT_HI 7
`define POF_FMT_LO 6
`define POF_RAMP_HI 5
`define POF_RAMP_LO 4
`define POF_BIT_SHIFT 3
`define POF_SYNC_PRE 16'hff00
`define POF_SYNC_SAV 16'h0080
`define POF_SYNC_EAV 16'h009d
`define POF_FIFO_W 17
`define POF_FIFO_D 32
`define POF_FIFO_AW 5

`endif

/* File: pof_pkg.sv */
/*
 * Types of the pixel output formatter: insertion states and field codes.
 * Assumes nothing of its surroundings.
 */
package pof_pkg;
    typedef enum logic [2:0] {
        POF_S_PIX = 3'b000,
        POF_S_SAV1 = 3'b001,
        POF_S_SAV2 = 3'b010,
        POF_S_EAV1 = 3'b011,
        POF_S_EAV2 = 3'b100
    } pof_state_t;
    typedef enum logic [1:0] {
        POF_RGB565 = 2'b00,
        POF_RGB555 = 2'b01,
        POF_RGB444X = 2'b10,
        POF_RGBX444 = 2'b11
    } pof_rgb_t;
    typedef enum logic [1:0] {
        POF_RAMP_OFF = 2'b00,
        POF_RAMP_COL = 2'b01,
        POF_RAMP_ROW = 2'b10,
        POF_RAMP_FRAME = 2'b11
    } pof_ramp_t;
endpackage : pof_pkg

/* File: pof_rx.sv */
/* Receiver model at the pixel port: samples bytes and pairs them into words.
   Assumes inv mirrors the clock-invert bit that the host has written. */
`timescale 1ns/100ps
module pof_rx (
    input wire logic pixel_out_clock,
    input wire logic inv,
    input wire logic byte_valid,
    input wire logic [7:0] pix_byte,
    output int words,
    output int faults
);
    logic [15:0] mem [256];
    logic [7:0] hi;
    logic [7:0] b;
    logic phase = 1'h0;
    realtime t_last = 0.0;
    realtime gap = 0.0;
    initial begin
        words = 0;
        faults = 0;
    end
    // A byte that moves 2 ns after the sampling edge was launched on that edge,
    // which a real receiver would capture wrongly.
    always @(pixel_out_clock) begin
        if (pixel_out_clock === inv && byte_valid === 1'h1) begin
            b = pix_byte;
            #2;
            if (pix_byte !== b) faults++;
            if (!phase) hi = b;
            else begin
                mem[words % 256] = {hi, b};
                gap = $realtime - t_last;
                t_last = $realtime;
                words++;
            end
            phase = ~phase;
        end
    end
endmodule : pof_rx

/* File: pof_tb.sv */
/* Bench of pof_top with the pof_rx receiver model.
   Assumes the checker binds itself to pof_top. */
`timescale 1ns/100ps
`include "pof_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    localparam logic [7:0] YV = 8'hc3, CV = 8'h5a, RV = 8'hf0, GV = 8'h3c, BV = 8'h8b;
    localparam logic [9:0] BYV = 10'h2a5, RWV = 10'h1d7;
    logic sys_clk = 1'h0, link_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, inv = 1'h1;
    logic in_valid = 1'h0, in_sof = 1'h0, in_sol = 1'h0, in_eol = 1'h0;
    logic [8:0] reg_addr = 9'h000;
    logic [15:0] reg_wdata = 16'h0000, rd, w, fr, reg_rdata;
    logic [7:0] in_y = YV, in_c = CV, in_r = RV, in_g = GV, in_b = BV, pix_byte;
    logic [9:0] in_bayer = BYV, in_raw = RWV;
    logic in_ready, auto_loops_enable, pixel_out_clock, byte_valid;
    int n_errors = 0, cmp_count = 0, seen = 0, stalls = 0, rx_words, rx_faults;
    pof_top DUT (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .in_valid,
        .in_ready, .in_sof, .in_sol, .in_eol, .in_y, .in_c, .in_r, .in_g, .in_b, .in_bayer,
        .in_raw, .auto_loops_enable, .link_clk, .pixel_out_clock, .pix_byte, .byte_valid);
    pof_rx u_rx (.pixel_out_clock, .inv, .byte_valid, .pix_byte, .words(rx_words),
        .faults(rx_faults));
    always #2.5 sys_clk = ~sys_clk;
    initial #1.3 forever #32 link_clk = ~link_clk;
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rdr(input logic [8:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rdr
    // Entered at a rising edge; leaves in_valid high so pixels can follow back to back.
    task automatic push(input logic f, input logic l, input logic e);
        in_sof <= f;
        in_sol <= l;
        in_eol <= e;
        in_valid <= 1'h1;
        for (int k = 0; k < 400; k++) begin
            @(negedge sys_clk);
            if (in_ready === 1'h1) break;
            stalls++;
        end
        @(posedge sys_clk);
    endtask : push
    task automatic getw(output logic [15:0] v);
        for (int k = 0; k < 3000 && rx_words <= seen; k++) @(posedge sys_clk);
        if (rx_words <= seen) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rx_words, seen + 1);
        end
        v = u_rx.mem[seen % 256];
        seen++;
    endtask : getw
    task automatic setc(input logic [15:0] c);
        wr(`POF_ADDR_CTRL, c);
        inv <= c[`POF_BIT_INV];
        repeat (40) @(posedge sys_clk);
    endtask : setc
    function automatic logic [15:0] expw(input logic [15:0] c);
        logic [7:0] r, g, b;
        r = c[3] ? RV << 3 : RV;
        g = c[3] ? GV << 3 : GV;
        b = c[3] ? BV << 3 : BV;
        if (c[10]) return {RWV[9:2], 6'h00, RWV[1:0]};
        if (c[14]) return {BYV[9:2], 6'h00, BYV[1:0]};
        if (!c[8]) return c[3] ? {CV << 3, YV << 3} : {CV, YV};
        case (c[7:6])
            2'h0: return {r[7:3], g[7:2], b[7:3]};
            2'h1: return {1'h0, r[7:3], g[7:3], b[7:3]};
            2'h2: return {r[7:4], g[7:4], b[7:4], 4'h0};
            default: return {4'h0, r[7:4], g[7:4], b[7:4]};
        endcase
    endfunction : expw
    task automatic t_regs;
        rdr(`POF_ADDR_CTRL, rd);
        `CHK(rd, 16'h0200)
        rdr(9'h000, rd);
        `CHK(rd, 16'h0000)
        wr(`POF_ADDR_CTRL, 16'hffff);
        rdr(`POF_ADDR_CTRL, rd);
        `CHK(rd, 16'h4ff8)
        rdr(`POF_ADDR_FRAME, fr);
        wr(`POF_ADDR_FRAME, ~fr);
        rdr(`POF_ADDR_FRAME, rd);
        `CHK(rd, fr)
    endtask : t_regs
    task automatic t_fmt;
        logic [15:0] cs [11] = '{16'h0200, 16'h0000, 16'h0100, 16'h0140, 16'h0180, 16'h01c0,
            16'h0108, 16'h0208, 16'h4000, 16'h0400, 16'h4500};
        for (int i = 0; i < 11; i++) begin
            setc(cs[i]);
            rdr(`POF_ADDR_FRAME, fr);
            @(posedge sys_clk);
            push(1'h1, 1'h1, 1'h1);
            in_valid <= 1'h0;
            getw(w);
            `CHK(w, expw(cs[i]))
            `CHK(auto_loops_enable, 1'h1)
            repeat (20) @(posedge sys_clk);
            rdr(`POF_ADDR_FRAME, rd);
            `CHK(rd, fr + 16'h0001)
        end
        `CHK(rx_faults, 0)
    endtask : t_fmt
    task automatic t_sync;
        logic [15:0] sq [5] = '{`POF_SYNC_PRE, `POF_SYNC_SAV, {CV, YV}, `POF_SYNC_PRE,
            `POF_SYNC_EAV};
        setc(16'h0800);
        rdr(`POF_ADDR_FRAME, fr);
        @(posedge sys_clk);
        push(1'h1, 1'h1, 1'h1);
        in_valid <= 1'h0;
        for (int k = 0; k < 5; k++) begin
            getw(w);
            `CHK(w, sq[k])
        end
        repeat (20) @(posedge sys_clk);
        rdr(`POF_ADDR_FRAME, rd);
        `CHK(rd, fr + 16'h0001)
    endtask : t_sync
    task automatic t_ramp;
        logic [7:0] e;
        logic [7:0] ce [4] = '{8'h00, 8'h01, 8'h02, 8'h00};
        logic [7:0] re [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
        logic [15:0] mc [3] = '{16'h0010, 16'h0020, 16'h0030};
        for (int m = 0; m < 3; m++) begin
            setc(mc[m]);
            rdr(`POF_ADDR_FRAME, fr);
            @(posedge sys_clk);
            push(1'h1, 1'h1, 1'h0);
            push(1'h0, 1'h0, 1'h0);
            push(1'h0, 1'h0, 1'h1);
            push(1'h0, 1'h1, 1'h1);
            in_valid <= 1'h0;
            for (int k = 0; k < 4; k++) begin
                getw(w);
                e = (m == 0) ? ce[k] : (m == 1) ? re[k] : fr[7:0];
                `CHK(w, {e, e})
            end
        end
    endtask : t_ramp
    task automatic t_fill;
        logic [9:0] v;
        setc(16'h0400);
        stalls = 0;
        for (int k = 0; k < 40; k++) begin
            in_raw <= 10'(k * 37);
            push(k == 0, k == 0, 1'h0);
        end
        in_valid <= 1'h0;
        `CHK(stalls > 0, 1'h1)
        for (int k = 0; k < 40; k++) begin
            v = 10'(k * 37);
            getw(w);
            `CHK(w, {v[9:2], 6'h00, v[1:0]})
        end
        `CHK(u_rx.gap == 256.0, 1'h1)
    endtask : t_fill
    task automatic stop_test;
        $display("mismatches %0d of %0d compares", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        n_errors++;
        stop_test;
    end
    // The link domain needs three of its own edges in reset, longer than six cycles.
    initial begin
        repeat (6) @(posedge sys_clk);
        repeat (3) @(posedge link_clk);
        @(posedge sys_clk);
        rst_n <= 1'h1;
        t_regs;
        t_fmt;
        t_sync;
        t_ramp;
        t_fill;
        stop_test;
    end
endmodule : testbench

/* File: pof_top.sv */
/*
 * Pixel output formatter: control and frame index registers, format
 * selection, sync code insertion, a dual-clock 32-word FIFO and the byte
 * launcher on the link clock. Assumes the pixel source runs on sys_clk and
 * that link_clk is a free-running clock at four times the output pixel rate.
 */
`timescale 1ns/100ps
`include "pof_defs.svh"

module pof_fifo #(
    parameter int W = 17,
    parameter int D = 32,
    parameter int AW = 5
) (
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [D];
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] wq1, wq2, rq1, rq2;
    wire [AW:0] wbin_nx = wbin + (AW+1)'(wr_valid && wr_ready);
    wire [AW:0] rbin_nx = rbin + (AW+1)'(rd_valid && rd_ready);
    // Full compares gray pointers: top two bits inverted means a lap ahead.
    assign wr_ready = wgray != {~rq2[AW:AW-1], rq2[AW-2:0]};
    assign rd_valid = rgray != wq2;
    assign rd_data = mem[rbin[AW-1:0]];

    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem[wbin[AW-1:0]] <= wr_data;
        end
    end
    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin <= '0;
            wgray <= '0;
            rq1 <= '0;
            rq2 <= '0;
        end else begin
            wbin <= wbin_nx;
            wgray <= wbin_nx ^ (wbin_nx >> 1);
            rq1 <= rgray;
            rq2 <= rq1;
        end
    end
    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin <= '0;
            rgray <= '0;
            wq1 <= '0;
            wq2 <= '0;
        end else begin
            rbin <= rbin_nx;
            rgray <= rbin_nx ^ (rbin_nx >> 1);
            wq1 <= wgray;
            wq2 <= wq1;
        end
    end
endmodule : pof_fifo

module pof_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_sof,
    input wire logic in_sol,
    input wire logic in_eol,
    input wire logic [7:0] in_y,
    input wire logic [7:0] in_c,
    input wire logic [7:0] in_r,
    input wire logic [7:0] in_g,
    input wire logic [7:0] in_b,
    input wire logic [9:0] in_bayer,
    input wire logic [9:0] in_raw,
    output logic auto_loops_enable,
    input wire logic link_clk,
    output logic pixel_out_clock,
    output logic [7:0] pix_byte,
    output logic byte_valid
);
    logic [15:0] ctrl;
    logic [15:0] frame_index;
    logic [7:0] col;
    logic [7:0] row;
    logic sav_done;
    logic fifo_wready;
    pof_pkg::pof_state_t state, next_state;

    function automatic logic [7:0] sh3(input logic [7:0] x, input logic en);
        sh3 = en ? {x[4:0], 3'h0} : x;
    endfunction : sh3

    wire shift_on = ctrl[`POF_BIT_SHIFT];
    wire sync_on = ctrl[`POF_BIT_SYNC];
    wire pof_pkg::pof_rgb_t rgb_fmt = pof_pkg::pof_rgb_t'(ctrl[`POF_FMT_HI:`POF_FMT_LO]);
    wire pof_pkg::pof_ramp_t ramp = pof_pkg::pof_ramp_t'(ctrl[`POF_RAMP_HI:`POF_RAMP_LO]);
    wire [7:0] r8 = sh3(in_r, shift_on);
    wire [7:0] g8 = sh3(in_g, shift_on);
    wire [7:0] b8 = sh3(in_b, shift_on);
    wire [7:0] col_now = in_sol ? 8'h00 : col;
    wire [7:0] row_now = in_sof ? 8'h00 : (in_sol ? row + 8'h01 : row);

    // Output word selection; the ramp overrides everything else.
    wire [15:0] rgb_word =
        (rgb_fmt == pof_pkg::POF_RGB565) ? {r8[7:3], g8[7:2], b8[7:3]} :
        (rgb_fmt == pof_pkg::POF_RGB555) ? {1'b0, r8[7:3], g8[7:3], b8[7:3]} :
        (rgb_fmt == pof_pkg::POF_RGB444X) ? {r8[7:4], g8[7:4], b8[7:4], 4'h0} :
        {4'h0, r8[7:4], g8[7:4], b8[7:4]};
    wire [15:0] yc_word = {sh3(in_c, shift_on), sh3(in_y, shift_on)};
    wire [15:0] proc_word = ctrl[`POF_BIT_RGB] ? rgb_word : yc_word;
    // Both 10-bit paths leave as an 8-bit byte then a 2-bit byte, so bytes per pixel stay two.
    wire [15:0] raw_word = {in_raw[9:2], 6'h00, in_raw[1:0]};
    wire [15:0] bayer_word = {in_bayer[9:2], 6'h00, in_bayer[1:0]};
    wire [15:0] img_word = ctrl[`POF_BIT_BYPASS] ? raw_word :
        (ctrl[`POF_BIT_BAYER] ? bayer_word : proc_word);
    wire [7:0] ramp_val = (ramp == pof_pkg::POF_RAMP_COL) ? col_now :
        (ramp == pof_pkg::POF_RAMP_ROW) ? row_now : frame_index[7:0];
    wire [15:0] pix_word = (ramp == pof_pkg::POF_RAMP_OFF) ? img_word :
        {ramp_val, ramp_val};

    wire need_sav = sync_on && in_sol && !sav_done;
    wire in_take = in_valid && in_ready;
    assign in_ready = (state == pof_pkg::POF_S_PIX) && !need_sav && fifo_wready;
    wire fifo_wvalid = (state != pof_pkg::POF_S_PIX) || (in_valid && !need_sav);
    wire [15:0] sync_word =
        (state == pof_pkg::POF_S_SAV2) ? `POF_SYNC_SAV :
        (state == pof_pkg::POF_S_EAV2) ? `POF_SYNC_EAV : `POF_SYNC_PRE;
    // With sync on the preamble carries the frame mark, so the pixel after it must not.
    wire mark_sof = in_sof && (sync_on ? (state == pof_pkg::POF_S_SAV1) :
        (state == pof_pkg::POF_S_PIX));
    wire [16:0] fifo_wdata = {mark_sof, (state == pof_pkg::POF_S_PIX) ? pix_word : sync_word};
    wire fifo_push = fifo_wvalid && fifo_wready;

    always_comb begin
        next_state = state;
        case (state)
            pof_pkg::POF_S_PIX: begin
                if (in_valid && need_sav) begin
                    next_state = pof_pkg::POF_S_SAV1;
                end else if (in_take && in_eol && sync_on) begin
                    next_state = pof_pkg::POF_S_EAV1;
                end
            end
            pof_pkg::POF_S_SAV1: begin
                if (fifo_push) begin
                    next_state = pof_pkg::POF_S_SAV2;
                end
            end
            pof_pkg::POF_S_EAV1: begin
                if (fifo_push) begin
                    next_state = pof_pkg::POF_S_EAV2;
                end
            end
            pof_pkg::POF_S_SAV2, pof_pkg::POF_S_EAV2: begin
                if (fifo_push) begin
                    next_state = pof_pkg::POF_S_PIX;
                end
            end
            default: begin
                next_state = pof_pkg::POF_S_PIX;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pof_pkg::POF_S_PIX;
            sav_done <= 1'b0;
        end else begin
            state <= next_state;
            if (state == pof_pkg::POF_S_SAV2 && fifo_push) begin
                sav_done <= 1'b1;
            end else if (in_take) begin
                sav_done <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            col <= 8'h00;
            row <= 8'h00;
        end else if (in_take) begin
            col <= col_now + 8'h01;
            row <= row_now;
        end
    end

    // Register port; only the defined control bits are stored.
    wire ctrl_we = reg_wr && (reg_addr == `POF_ADDR_CTRL);
    wire [15:0] rd_mux = (reg_addr == `POF_ADDR_FRAME) ? frame_index :
        (reg_addr == `POF_ADDR_CTRL) ? ctrl : 16'h0000;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `POF_CTRL_RESET;
            reg_rdata <= 16'h0000;
            auto_loops_enable <= 1'b0;
        end else begin
            if (ctrl_we) begin
                ctrl <= reg_wdata & `POF_CTRL_MASK;
            end
            reg_rdata <= rd_mux;
            // The statistics loops tap the sensor side, so bypass never stops them.
            auto_loops_enable <= 1'b1;
        end
    end

    // Link clock reset: asserted at once, released after two link edges.
    logic lrst_a, lrst_n;
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_a <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_a <= 1'b1;
            lrst_n <= lrst_a;
        end
    end

    logic rd_valid, rd_ready;
    logic [16:0] rd_data;
    pof_fifo #(
        .W(`POF_FIFO_W),
        .D(`POF_FIFO_D),
        .AW(`POF_FIFO_AW)
    ) u_fifo (
        .wr_clk(sys_clk),
        .wr_rst_n(rst_n),
        .wr_valid(fifo_wvalid),
        .wr_ready(fifo_wready),
        .wr_data(fifo_wdata),
        .rd_clk(link_clk),
        .rd_rst_n(lrst_n),
        .rd_valid(rd_valid),
        .rd_ready(rd_ready),
        .rd_data(rd_data)
    );

    // The invert bit is quasi-static, so a plain two-stage sync suffices.
    logic inv_q1, inv_q2;
    logic lo_pend, sof_tgl;
    logic [7:0] lo_byte;
    wire next_clk = ~pixel_out_clock;
    // Launch when the output clock rises (invert clear) or falls (invert set).
    wire launch = next_clk ^ inv_q2;
    assign rd_ready = launch && !lo_pend;

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            inv_q1 <= 1'b1;
            inv_q2 <= 1'b1;
            pixel_out_clock <= 1'b0;
            pix_byte <= 8'h00;
            byte_valid <= 1'b0;
            lo_pend <= 1'b0;
            lo_byte <= 8'h00;
            sof_tgl <= 1'b0;
        end else begin
            inv_q1 <= ctrl[`POF_BIT_INV];
            inv_q2 <= inv_q1;
            pixel_out_clock <= next_clk;
            if (launch) begin
                if (lo_pend) begin
                    pix_byte <= lo_byte;
                    lo_pend <= 1'b0;
                    byte_valid <= 1'b1;
                end else if (rd_valid) begin
                    pix_byte <= rd_data[15:8];
                    lo_byte <= rd_data[7:0];
                    lo_pend <= 1'b1;
                    byte_valid <= 1'b1;
                    sof_tgl <= sof_tgl ^ rd_data[16];
                end else begin
                    byte_valid <= 1'b0;
                end
            end
        end
    end

    // Frame starts come back as a toggle and step the index here.
    logic sof_q1, sof_q2, sof_q3;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sof_q1 <= 1'b0;
            sof_q2 <= 1'b0;
            sof_q3 <= 1'b0;
            frame_index <= 16'h0000;
        end else begin
            sof_q1 <= sof_tgl;
            sof_q2 <= sof_q1;
            sof_q3 <= sof_q2;
            if (sof_q2 != sof_q3) begin
                frame_index <= frame_index + 16'h0001;
            end
        end
    end
endmodule : pof_top

/* File: pof_top_chk_sva.sv */
/* Port checker of pof_top: register read-back and the link byte launcher.
   Assumes the bind below, sys_clk and link_clk sharing rst_n. */
`timescale 1ns/100ps
`include "pof_defs.svh"
module pof_top_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic auto_loops_enable,
    input wire logic link_clk,
    input wire logic pixel_out_clock,
    input wire logic [7:0] pix_byte,
    input wire logic byte_valid
);
    rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(reg_addr) == `POF_ADDR_CTRL |-> (reg_rdata & ~`POF_CTRL_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    other_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(reg_addr) != `POF_ADDR_CTRL && $past(reg_addr) != `POF_ADDR_FRAME
        |-> reg_rdata == 16'h0000) else $error("unmapped address reads nonzero");
    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && reg_addr == `POF_ADDR_CTRL ##1 (!reg_wr && reg_addr == `POF_ADDR_CTRL) [*2]
        |=> reg_rdata == ($past(reg_wdata, 3) & `POF_CTRL_MASK)) else $error("bad read-back");
    loops_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |-> auto_loops_enable) else $error("auto loops stopped");
    clk_toggle_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        $past(rst_n, 4) && $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
        |-> pixel_out_clock != $past(pixel_out_clock)) else $error("pixel clock stuck");
    byte_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        $changed(pix_byte) |=> $stable(pix_byte)) else $error("byte held one cycle only");
    valid_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        $changed(byte_valid) |=> $stable(byte_valid)) else $error("valid held one cycle only");
    pair_whole_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(byte_valid) |-> byte_valid [*4]) else $error("byte pair split");
    cover property (@(posedge sys_clk) disable iff (!rst_n) in_valid && !in_ready);
    cover property (@(posedge link_clk) disable iff (!rst_n) $rose(byte_valid));
    cover property (@(posedge sys_clk) disable iff (!rst_n) reg_wr);
endmodule : pof_top_chk
bind pof_top pof_top_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .in_valid, .in_ready, .auto_loops_enable, .link_clk, .pixel_out_clock, .pix_byte,
    .byte_valid);
